// [sacs_core_model.sv]
// model: analog core answering with a code built from its selection
`timescale 1ns/1ps
module sacs_core_model (
  // clock
  input wire logic                       pclk,
  // selection and strobes
  input wire logic [sacs_pkg::CH_W-1:0]  core_channel,
  input wire logic [sacs_pkg::REF_W-1:0] core_reference,
  input wire logic                       core_hold,
  input wire logic                       core_latch,
  // result
  output logic     [sacs_pkg::RES_W-1:0] core_data
);
  logic [9:0] held_r;
  logic       valid_r;
  initial begin
    held_r  = 10'h000;
    valid_r = 1'b0;
  end
  // outside hold-to-latch the lines show the inverse, so a capture
  // at the wrong moment cannot pass by chance
  always @(posedge pclk) begin
    if (core_hold) begin
      held_r  <= {1'b1, core_reference, 2'h0, core_channel};
      valid_r <= 1'b1;
    end else if (core_latch) begin
      valid_r <= 1'b0;
    end
  end
  assign core_data = valid_r ? held_r : ~held_r;
endmodule // sacs_core_model

// [sacs_div.sv]
// module: ADC clock divider producing one-cycle rising-edge enable pulses
`timescale 1ns/1ps
module sacs_div (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  sacs_div_if.div   dif
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } sacs_div_st_t;
  sacs_div_st_t s_r;
  sacs_div_st_t s_nxt;
  logic [8:0] half;
  // ----------------------------------------------------------------------
  // divide by 2^(sel+1); rising edge of divided clock at half period
  // ----------------------------------------------------------------------
  always_comb begin
    half  = 9'(9'h001 << dif.sel);
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!dif.run) begin
      s_nxt.cnt = 9'h000;
    end else begin
      s_nxt.cnt = 9'(s_r.cnt + 9'h001);
      if (s_r.cnt == 9'(half - 9'h001)) begin
        s_nxt.tick = 1'b1;
      end
      if (s_r.cnt == 9'(half + half - 9'h001)) begin
        s_nxt.cnt = 9'h000;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign dif.tick = s_r.tick;
endmodule // sacs_div

// [sacs_div_if.sv]
// interface: divider control and enable pulse between sequencer and divider
`timescale 1ns/1ps
interface sacs_div_if;
  logic                   run;
  logic [sacs_pkg::DIV_W-1:0] sel;
  logic                   tick;
  modport ctl (output run, output sel, input tick);
  modport div (input run, input sel, output tick);
endinterface

// [sacs_pkg.sv]
// package: register map, field layout and timing constants of the sequencer
package sacs_pkg;
  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_CMD      = 12'h004;
  localparam logic [11:0] OFS_SEL      = 12'h008;
  localparam logic [11:0] OFS_TIMING   = 12'h00C;
  localparam logic [11:0] OFS_INTEN    = 12'h010;
  localparam logic [11:0] OFS_FLAGS    = 12'h014;
  localparam logic [11:0] OFS_RESULT   = 12'h018;
  localparam logic [11:0] OFS_ACTIVE   = 12'h01C;
  localparam logic [11:0] OFS_DBG      = 12'h020;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_RES_BIT   = 2;
  localparam int CTRL_CONT_BIT  = 1;
  localparam int CTRL_EVEN_BIT  = 3;
  localparam int CTRL_ACC_LSB   = 4;
  localparam int CTRL_DIV_LSB   = 8;
  localparam int SEL_CH_LSB     = 0;
  localparam int SEL_REF_LSB    = 8;
  localparam int TIM_DLY_LSB    = 0;
  localparam int TIM_LEN_LSB    = 8;
  // ----------------------------------------------------------------------
  // widths, reset values and timing counts
  // ----------------------------------------------------------------------
  localparam int RES_W  = 10;
  localparam int ACC_W  = 16;
  localparam int CH_W   = 4;
  localparam int REF_W  = 3;
  localparam int DIV_W  = 3;
  localparam int TIM_W  = 4;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [4:0] CONV_CYCLES  = 5'h0D;
  localparam logic [4:0] SH_CYCLE     = 5'h02;
  localparam logic [4:0] SAMPLE_BASE  = 5'h02;
  localparam int START_EXTRA = 2;
  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_CONV  = 2'b10
  } sacs_state_t;
endpackage

// [sacs_seq.sv]
// module: SAR converter sequencer with APB registers
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module sacs_seq (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // event router and debug
  input  wire logic                        event_in,
  input  wire logic                        debug_halt,
  // analog core
  input  wire logic [sacs_pkg::RES_W-1:0]  core_data,
  output logic      [sacs_pkg::CH_W-1:0]   core_channel,
  output logic      [sacs_pkg::REF_W-1:0]  core_reference,
  output logic                             core_enable,
  output logic                             core_sample,
  output logic                             core_hold,
  output logic                             core_latch,
  // interrupt request
  output logic                             result_irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    sacs_pkg::sacs_state_t             st;
    logic                              enable;
    logic                              continuous_mode;
    logic                              resolution_select;
    logic                              event_start_enable;
    logic [2:0]                        accumulation_count;
    logic [sacs_pkg::DIV_W-1:0]        clock_divider_select;
    logic [sacs_pkg::CH_W-1:0]         hold_channel;
    logic [sacs_pkg::REF_W-1:0]        hold_reference;
    logic [sacs_pkg::CH_W-1:0]         input_channel_select;
    logic [sacs_pkg::REF_W-1:0]        reference_select;
    logic [sacs_pkg::TIM_W-1:0]        sample_delay;
    logic [sacs_pkg::TIM_W-1:0]        sample_length;
    logic                              debug_run;
    logic                              start_conversion;
    logic                              result_ready;
    logic                              result_irq_en;
    logic [sacs_pkg::ACC_W-1:0]        result;
    logic [sacs_pkg::ACC_W-1:0]        acc;
    logic [6:0]                        samples;
    logic [5:0]                        phase;
    logic                              sample;
    logic                              hold;
    logic                              latch;
    logic                              irq;
    logic [31:0]                       rdata;
    logic                              ready;
    logic [2:0]                        ev_sync;
    logic                              ev_seen;
  } sacs_st_t;
  sacs_st_t s_r;
  sacs_st_t s_nxt;
  sacs_div_if dif ();
  logic       wr;
  logic       rd;
  logic       go;
  logic       ev_edge;
  logic [5:0] conv_len;
  logic [5:0] samp_end;
  logic [6:0] acc_target;
  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  sacs_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dif     (dif.div)
  );
  // the divider only runs during a conversion so the start delay is fixed
  assign dif.run = s_r.enable && (s_r.st != sacs_pkg::ST_IDLE);
  assign dif.sel = s_r.clock_divider_select;
  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    wr         = psel && penable && pwrite && !s_r.ready;
    rd         = psel && penable && !pwrite && !s_r.ready;
    // debug halt freezes the divided-clock steps, not the registers
    // a tick still in flight after disabling must not strobe the core
    go         = dif.tick && s_r.enable
               && (!debug_halt || s_r.debug_run);
    // second and third stage agree high while the settled level was low
    ev_edge    = s_r.ev_sync[1] && s_r.ev_sync[2] && !s_r.ev_seen;
    conv_len   = 6'(sacs_pkg::CONV_CYCLES) + 6'(s_r.sample_delay)
               + 6'(s_r.sample_length);
    samp_end   = 6'(sacs_pkg::SAMPLE_BASE) + 6'(s_r.sample_delay)
               + 6'(s_r.sample_length);
    acc_target = 7'(7'h01 << s_r.accumulation_count);
    s_nxt.ev_sync = {s_r.ev_sync[1:0], event_in};
    if (s_r.ev_sync[1] == s_r.ev_sync[2]) begin
      s_nxt.ev_seen = s_r.ev_sync[2];
    end
    s_nxt.ready   = psel && penable && !s_r.ready;
    s_nxt.latch   = 1'b0;
    s_nxt.hold    = 1'b0;
    // holding register feeds active selection while idle
    if (s_r.st == sacs_pkg::ST_IDLE) begin
      s_nxt.input_channel_select = s_r.hold_channel;
      s_nxt.reference_select     = s_r.hold_reference;
    end
    // register writes
    if (wr) begin
      unique case (paddr)
        sacs_pkg::OFS_CTRL: begin
          s_nxt.enable             = pwdata[sacs_pkg::CTRL_EN_BIT];
          s_nxt.continuous_mode    = pwdata[sacs_pkg::CTRL_CONT_BIT];
          s_nxt.resolution_select  = pwdata[sacs_pkg::CTRL_RES_BIT];
          s_nxt.event_start_enable = pwdata[sacs_pkg::CTRL_EVEN_BIT];
          s_nxt.accumulation_count =
            pwdata[sacs_pkg::CTRL_ACC_LSB +: 3];
          s_nxt.clock_divider_select =
            pwdata[sacs_pkg::CTRL_DIV_LSB +: sacs_pkg::DIV_W];
        end
        sacs_pkg::OFS_CMD: begin
          if (pwdata[0]) begin
            s_nxt.start_conversion = 1'b1;
          end
        end
        sacs_pkg::OFS_SEL: begin
          s_nxt.hold_channel   = pwdata[sacs_pkg::SEL_CH_LSB +: sacs_pkg::CH_W];
          s_nxt.hold_reference =
            pwdata[sacs_pkg::SEL_REF_LSB +: sacs_pkg::REF_W];
        end
        sacs_pkg::OFS_TIMING: begin
          s_nxt.sample_delay  = pwdata[sacs_pkg::TIM_DLY_LSB +: sacs_pkg::TIM_W];
          s_nxt.sample_length = pwdata[sacs_pkg::TIM_LEN_LSB +: sacs_pkg::TIM_W];
        end
        sacs_pkg::OFS_INTEN: s_nxt.result_irq_en = pwdata[0];
        sacs_pkg::OFS_FLAGS: begin
          if (pwdata[0]) begin
            s_nxt.result_ready = 1'b0;
          end
        end
        sacs_pkg::OFS_DBG: s_nxt.debug_run = pwdata[0];
        default: begin
        end
      endcase
    end
    if (rd && paddr == sacs_pkg::OFS_RESULT) begin
      s_nxt.result_ready = 1'b0;
    end
    if (s_r.event_start_enable && ev_edge && s_r.enable) begin
      s_nxt.start_conversion = 1'b1;
    end
    // conversion sequence
    unique case (s_r.st)
      sacs_pkg::ST_IDLE: begin
        if (s_r.enable && s_r.start_conversion) begin
          s_nxt.st      = sacs_pkg::ST_ARM;
          s_nxt.acc     = '0;
          s_nxt.samples = 7'h00;
        end
      end
      sacs_pkg::ST_ARM: begin
        // first divided rising edge begins the conversion
        if (go) begin
          s_nxt.st     = sacs_pkg::ST_CONV;
          s_nxt.phase  = 6'h00;
          s_nxt.sample = 1'b1;
        end
      end
      sacs_pkg::ST_CONV: begin
        if (go) begin
          s_nxt.phase = 6'(s_r.phase + 6'h01);
          if (6'(s_r.phase + 6'h01) == 6'(sacs_pkg::SH_CYCLE)) begin
            s_nxt.hold = 1'b1;
          end
          if (6'(s_r.phase + 6'h01) == samp_end) begin
            s_nxt.sample = 1'b0;
          end
          // last divided cycle: let new selections through
          if (6'(s_r.phase + 6'h02) == conv_len) begin
            s_nxt.input_channel_select = s_r.hold_channel;
            s_nxt.reference_select     = s_r.hold_reference;
          end
          if (6'(s_r.phase + 6'h01) == conv_len) begin
            s_nxt.latch   = 1'b1;
            s_nxt.phase   = 6'h00;
            s_nxt.sample  = 1'b1;
            s_nxt.samples = 7'(s_r.samples + 7'h01);
            s_nxt.acc     = 16'(s_r.acc + 16'(core_data));
            if (7'(s_r.samples + 7'h01) == acc_target) begin
              // 10 bits right adjusted; accumulation widens it
              s_nxt.result       = 16'(s_r.acc + 16'(core_data));
              s_nxt.result_ready = 1'b1;
              s_nxt.acc          = '0;
              s_nxt.samples      = 7'h00;
              if (!s_r.continuous_mode) begin
                s_nxt.start_conversion = 1'b0;
                s_nxt.st               = sacs_pkg::ST_IDLE;
                s_nxt.sample           = 1'b0;
              end else if (!s_nxt.start_conversion) begin
                s_nxt.st     = sacs_pkg::ST_IDLE;
                s_nxt.sample = 1'b0;
              end
              // otherwise stay busy: next conversion, already-copied select
            end
          end
        end
      end
      default: s_nxt.st = sacs_pkg::ST_IDLE;
    endcase
    if (!s_r.enable) begin
      s_nxt.st               = sacs_pkg::ST_IDLE;
      s_nxt.sample           = 1'b0;
      s_nxt.start_conversion = s_nxt.start_conversion && s_r.enable;
    end
    s_nxt.irq = s_nxt.result_ready && s_nxt.result_irq_en;
    // read mux
    s_nxt.rdata = sacs_pkg::RST_ZERO;
    if (rd) begin
      unique case (paddr)
        sacs_pkg::OFS_CTRL: s_nxt.rdata = {20'h00000,
          1'b0, s_r.clock_divider_select, 1'b0, s_r.accumulation_count,
          s_r.event_start_enable, s_r.resolution_select,
          s_r.continuous_mode, s_r.enable};
        sacs_pkg::OFS_CMD:    s_nxt.rdata = {31'h0, s_r.start_conversion};
        sacs_pkg::OFS_SEL:    s_nxt.rdata = {21'h0, s_r.hold_reference,
                                             4'h0, s_r.hold_channel};
        sacs_pkg::OFS_TIMING: s_nxt.rdata = {20'h0, s_r.sample_length,
                                             4'h0, s_r.sample_delay};
        sacs_pkg::OFS_INTEN:  s_nxt.rdata = {31'h0, s_r.result_irq_en};
        sacs_pkg::OFS_FLAGS:  s_nxt.rdata = {31'h0, s_r.result_ready};
        sacs_pkg::OFS_RESULT: s_nxt.rdata = {16'h0, s_r.result};
        sacs_pkg::OFS_ACTIVE: s_nxt.rdata = {21'h0, s_r.reference_select,
                                             4'h0, s_r.input_channel_select};
        sacs_pkg::OFS_DBG:    s_nxt.rdata = {31'h0, s_r.debug_run};
        default:              s_nxt.rdata = sacs_pkg::RST_ZERO;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata         = s_r.rdata;
  assign pready         = s_r.ready;
  assign pslverr        = 1'b0;
  assign core_channel   = s_r.input_channel_select;
  assign core_reference = s_r.reference_select;
  assign core_enable    = s_r.enable;
  assign core_sample    = s_r.sample;
  assign core_hold      = s_r.hold;
  assign core_latch     = s_r.latch;
  assign result_irq     = s_r.irq;
endmodule // sacs_seq

// [sacs_seq_monitor.sv]
// checker: port-level assertions on the sequencer
`timescale 1ns/1ps
module sacs_seq_monitor (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // core side
  input wire logic [sacs_pkg::CH_W-1:0]  core_channel,
  input wire logic [sacs_pkg::REF_W-1:0] core_reference,
  input wire logic                       core_enable,
  input wire logic                       core_sample,
  input wire logic                       core_hold,
  input wire logic                       core_latch,
  input wire logic                       result_irq
);
  // --------
  // cycles since the last conversion end, saturating
  // --------
  logic [7:0] gap_r;
  logic       seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r  <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= core_latch ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
      seen_r <= seen_r | core_latch;
    end
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_rd_res;
    psel && penable && pready && !pwrite && paddr == sacs_pkg::OFS_RESULT;
  endsequence
  a_ready_wait: assert property (s_wait |=> pready)
    else $error("access not answered next cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_no_error: assert property (!pslverr)
    else $error("error response seen");
  a_sel_frozen: assert property (
    core_sample && $past(core_sample) |->
      $stable(core_channel) && $stable(core_reference))
    else $error("selection moved during sampling");
  a_off_quiet: assert property (
    !core_enable && $past(!core_enable) |->
      !core_sample && !core_hold && !core_latch)
    else $error("core activity while disabled");
  a_hold_pulse: assert property (core_hold |=> !core_hold)
    else $error("hold strobe too long");
  // min factor 2 gives at least 26 cycles between conversion ends
  a_conv_gap: assert property (
    core_latch && seen_r |-> gap_r >= 8'h19)
    else $error("conversions closer than 13 ticks");
  a_read_clears: assert property (
    s_rd_res ##0 !core_latch ##1 !core_latch |-> !result_irq)
    else $error("irq held after result read");
endmodule // sacs_seq_monitor

bind sacs_seq sacs_seq_monitor u_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .core_channel, .core_reference,
  .core_enable, .core_sample, .core_hold, .core_latch, .result_irq);

// [sacs_seq_tb.sv]
// testbench: register-level scenarios for the conversion sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module sacs_seq_tb;
  // --------
  // signals
  // --------
  logic                       pclk, presetn, psel, penable, pwrite;
  logic                       event_in, debug_halt, pready, pslverr;
  logic                       core_enable, core_sample, core_hold;
  logic                       core_latch, result_irq;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, q;
  logic [sacs_pkg::RES_W-1:0] core_data;
  logic [sacs_pkg::CH_W-1:0]  core_channel;
  logic [sacs_pkg::REF_W-1:0] core_reference;
  logic [2:0]                 dv [3];
  logic [3:0]                 dl [3];
  logic [3:0]                 ln [3];
  int                         failures, num_checks, samp, gap, per, i, k;
  sacs_seq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .event_in, .debug_halt,
    .core_data, .core_channel, .core_reference, .core_enable,
    .core_sample, .core_hold, .core_latch, .result_irq);
  sacs_core_model u_core (.pclk, .core_channel, .core_reference,
    .core_hold, .core_latch, .core_data);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // --------
  // tasks
  // --------
  function automatic logic [31:0] code(logic [3:0] c, logic [2:0] r);
    return {22'h0, 1'b1, r, 2'h0, c};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // counts sampling cycles, hold-to-end cycles and total wait
  task automatic wait_latch(output int s, output int g, output int n);
    logic h;
    s = 0;
    g = 0;
    n = 0;
    h = 1'b0;
    while (n < 3000) begin
      @(posedge pclk);
      n++;
      if (n == 4) event_in <= 1'b0;
      if (core_sample === 1'b1) s++;
      if (h) g++;
      if (core_hold === 1'b1) h = 1'b1;
      if (core_latch === 1'b1) break;
    end
    if (n >= 3000) failures++;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    finish_test;
  end
  // --------
  // scenarios
  // --------
  initial begin
    failures = 0;
    num_checks = 0;
    {presetn, psel, penable, pwrite, event_in, debug_halt} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    dv = '{3'h0, 3'h1, 3'h2};
    dl = '{4'h1, 4'h0, 4'h3};
    ln = '{4'h2, 4'h0, 4'h1};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i++) rdchk(12'(i * 4), 32'h0);
    wr(12'h0FC, 32'hFFFF_FFFF);
    rdchk(12'h0FC, 32'h0);
    $display("reset and unmapped test done");
    for (i = 0; i < 3; i++) begin
      wr(sacs_pkg::OFS_SEL, {21'h0, 3'(i + 1), 4'h0, 4'(i + 5)});
      wr(sacs_pkg::OFS_TIMING, {20'h0, ln[i], 4'h0, dl[i]});
      wr(sacs_pkg::OFS_CTRL, {21'h0, dv[i], 8'h09});
      event_in <= 1'b1;
      wait_latch(samp, gap, per);
      k = 2 << dv[i];
      `CHK(samp, (2 + dl[i] + ln[i]) * k)
      `CHK(gap, (11 + dl[i] + ln[i]) * k)
      rdchk(sacs_pkg::OFS_CMD, 32'h0);
      rdchk(sacs_pkg::OFS_FLAGS, 32'h1);
      `CHK(result_irq, 1'b0)
      rdchk(sacs_pkg::OFS_RESULT, code(4'(i + 5), 3'(i + 1)));
      rdchk(sacs_pkg::OFS_FLAGS, 32'h0);
    end
    $display("event timing test done");
    wr(sacs_pkg::OFS_INTEN, 32'h1);
    wr(sacs_pkg::OFS_CTRL, 32'h1);
    wr(sacs_pkg::OFS_SEL, 32'h103);
    wr(sacs_pkg::OFS_CMD, 32'h1);
    rdchk(sacs_pkg::OFS_CMD, 32'h1);
    wr(sacs_pkg::OFS_SEL, 32'h409);
    rdchk(sacs_pkg::OFS_ACTIVE, 32'h103);
    wait_latch(samp, gap, per);
    repeat (2) @(posedge pclk);
    `CHK(result_irq, 1'b1)
    wr(sacs_pkg::OFS_FLAGS, 32'h1);
    `CHK(result_irq, 1'b0)
    rdchk(sacs_pkg::OFS_RESULT, code(4'h3, 3'h1));
    rdchk(sacs_pkg::OFS_ACTIVE, 32'h409);
    $display("channel change test done");
    wr(sacs_pkg::OFS_CTRL, 32'h3);
    wr(sacs_pkg::OFS_SEL, 32'h2);
    wr(sacs_pkg::OFS_CMD, 32'h1);
    wait_latch(samp, gap, per);
    wr(sacs_pkg::OFS_SEL, 32'h6);
    wait_latch(samp, gap, per);
    rdchk(sacs_pkg::OFS_RESULT, code(4'h2, 3'h0));
    wait_latch(samp, gap, per);
    wait_latch(samp, gap, per);
    `CHK(per, (13 + dl[2] + ln[2]) * 2)
    rdchk(sacs_pkg::OFS_RESULT, code(4'h6, 3'h0));
    rdchk(sacs_pkg::OFS_CMD, 32'h1);
    wr(sacs_pkg::OFS_CTRL, 32'h0);
    rdchk(sacs_pkg::OFS_CMD, 32'h0);
    $display("continuous test done");
    debug_halt <= 1'b1;
    wr(sacs_pkg::OFS_CTRL, 32'h1);
    wr(sacs_pkg::OFS_CMD, 32'h1);
    k = 0;
    repeat (100) begin
      @(posedge pclk);
      if (core_latch === 1'b1) k++;
    end
    `CHK(k, 0)
    wr(sacs_pkg::OFS_DBG, 32'h1);
    wait_latch(samp, gap, per);
    rdchk(sacs_pkg::OFS_FLAGS, 32'h1);
    rdchk(sacs_pkg::OFS_RESULT, code(4'h6, 3'h0));
    $display("debug halt test done");
    wr(sacs_pkg::OFS_SEL, 32'h207);
    wr(sacs_pkg::OFS_CTRL, 32'h11);
    wr(sacs_pkg::OFS_CMD, 32'h1);
    wait_latch(samp, gap, per);
    rdchk(sacs_pkg::OFS_FLAGS, 32'h0);
    wait_latch(samp, gap, per);
    rdchk(sacs_pkg::OFS_FLAGS, 32'h1);
    rdchk(sacs_pkg::OFS_RESULT, code(4'h7, 3'h2) << 1);
    $display("accumulation test done");
    finish_test;
  end
endmodule // sacs_seq_tb
